// ===== rtl/sps_consts.svh
// sps_consts.svh: register map, field positions and timing counts of the serial port
// assumes: included wherever these names are used; holds definitions only
`ifndef SPS_CONSTS_SVH
`define SPS_CONSTS_SVH

// register indices on the software port
`define SPS_ADDR_DATA   2'h0
`define SPS_ADDR_CTRL   2'h1
`define SPS_ADDR_STAT   2'h2
`define SPS_ADDR_PRESC  2'h3

// control register fields
`define SPS_CR_IRQ_EN   7
`define SPS_CR_OE       6
`define SPS_CR_IRQ_SRC  5
`define SPS_CR_MASTER   4
`define SPS_CR_CLOCK_IDLE_LEVEL     3
`define SPS_CR_CLOCK_PHASE_SEL     2
`define SPS_CR_RATE_HI  1
`define SPS_CR_RATE_LO  0

// status register fields
`define SPS_SR_DONE     7
`define SPS_SR_WRITE_COLLISION_FLAG     6
`define SPS_SR_MODE_FAULT_FLAG     4

// reset values
`define SPS_CTRL_RST    8'h00
`define SPS_PRESC_RST   8'h00
`define SPS_ZERO_BYTE   8'h00

// half periods of the master serial clock in system clocks for rate codes 0..3 (divide 2, 4, 16, 32)
`define SPS_HALF_R0     5'h01
`define SPS_HALF_R1     5'h02
`define SPS_HALF_R2     5'h08
`define SPS_HALF_R3     5'h10

// sixteen edges make the eight pulses of one byte
`define SPS_FIRST_EDGE  4'h0
`define SPS_LAST_EDGE   4'hf

// half period of the far-end master clock, in system clocks
`define SPS_PEER_HALF   8'h04

`endif

// ===== rtl/sps_pkg.sv
// sps_pkg.sv: types and the shared bit-step function of both ends of the serial link
// assumes: sps_consts.svh on the include path
package sps_pkg;
`include "sps_consts.svh"

    typedef logic [7:0] sps_byte_t;
    typedef logic [1:0] sps_addr_t;

    typedef enum logic [1:0] {
        SPS_IDLE  = 2'b00,
        SPS_SETUP = 2'b01,
        SPS_SHIFT = 2'b11,
        SPS_HOLD  = 2'b10
    } sps_phase_t;

    typedef struct packed {
        sps_byte_t shift;
        logic      latch;
        sps_byte_t rx;
    } sps_step_t;

    typedef struct packed {
        sps_byte_t  ctrl;
        sps_byte_t  presc;
        sps_byte_t  shift;
        sps_byte_t  rxbuf;
        sps_byte_t  rdata;
        logic       done_flag;
        logic       write_collision_flag_flag;
        logic       mode_fault_flag_flag;
        logic       done_arm;
        logic       write_collision_flag_arm;
        logic       mode_fault_flag_arm;
        logic       busy;
        logic [3:0] edge_cnt;
        logic [4:0] div_cnt;
        logic       sck;
        logic       sck_prev;
        logic       latch;
        logic       sck_oe_n;
        logic       mosi_oe_n;
        logic       miso_oe_n;
        logic       irq;
    } sps_dev_state_t;

    typedef struct packed {
        sps_phase_t phase;
        sps_byte_t  shift;
        sps_byte_t  rx;
        logic       latch;
        logic [3:0] edge_cnt;
        logic [7:0] div_cnt;
        logic       sck;
        logic       sck_prev;
        logic       ss_n;
        logic       done;
        logic       busy;
        logic       sck_oe_n;
        logic       mosi_oe_n;
        logic       miso_oe_n;
        logic       out_bit;
    } sps_peer_state_t;

    // one serial clock edge: sample on the capture edge, shift on the other
    // the first edge leaves the shifter alone: with phase set it is a launch edge and the MSB already sits on the pin
    function automatic sps_step_t sps_edge_step(sps_byte_t shift, logic latch, logic [3:0] cnt,
                                                logic clock_phase_sel, logic din);
        sps_step_t r;
        r.shift = shift;
        r.latch = latch;
        r.rx    = {shift[6:0], (clock_phase_sel ? din : latch)};
        if (cnt[0] == clock_phase_sel) begin
            r.latch = din;
        end else if (cnt != `SPS_FIRST_EDGE) begin
            r.shift = {shift[6:0], latch};
        end
        return r;
    endfunction : sps_edge_step

endpackage : sps_pkg

// ===== rtl/sps_if.sv
// sps_if.sv: the four-wire serial link between the port and the far end
// assumes: each end drives sck, mosi and miso only while its active-low enable is low; the far end always drives ss_n; idle wires read high
`timescale 1ns/1ps
interface sps_if;
    logic dev_sck_o;
    logic dev_sck_oe_n;
    logic dev_mosi_o;
    logic dev_mosi_oe_n;
    logic dev_miso_o;
    logic dev_miso_oe_n;
    logic peer_sck_o;
    logic peer_sck_oe_n;
    logic peer_mosi_o;
    logic peer_mosi_oe_n;
    logic peer_miso_o;
    logic peer_miso_oe_n;
    logic ss_n;
    logic sck;
    logic mosi;
    logic miso;

    // wire resolution, pulled high when nobody drives
    assign sck  = !dev_sck_oe_n  ? dev_sck_o  : (!peer_sck_oe_n  ? peer_sck_o  : 1'b1);
    assign mosi = !dev_mosi_oe_n ? dev_mosi_o : (!peer_mosi_oe_n ? peer_mosi_o : 1'b1);
    assign miso = !dev_miso_oe_n ? dev_miso_o : (!peer_miso_oe_n ? peer_miso_o : 1'b1);

    modport dev (
        output dev_sck_o, dev_sck_oe_n, dev_mosi_o, dev_mosi_oe_n, dev_miso_o, dev_miso_oe_n,
        input  sck, mosi, miso, ss_n
    );
    modport peer (
        output peer_sck_o, peer_sck_oe_n, peer_mosi_o, peer_mosi_oe_n, peer_miso_o, peer_miso_oe_n, ss_n,
        input  sck, mosi, miso
    );
endinterface : sps_if

// ===== rtl/sps_peer.sv
// sps_peer.sv: far end of the serial link, either a fixed-rate master or a plain slave
// assumes: role and clock mode are held steady while busy_o is high; start_i is a one-cycle pulse
`timescale 1ns/1ps
`include "sps_consts.svh"
module sps_peer #(
    parameter logic [7:0] HALF_DIV = `SPS_PEER_HALF
) (
    input  wire logic             clock_i,
    input  wire logic             nrst_i,
    input  wire logic             peer_master_i,
    input  wire logic             clock_idle_level_i,
    input  wire logic             clock_phase_sel_i,
    input  wire sps_pkg::sps_byte_t tx_byte_i,
    input  wire logic             start_i,
    output sps_pkg::sps_byte_t    rx_byte_o,
    output logic                  done_o,
    output logic                  busy_o,
    sps_if.peer                   link
);
    import sps_pkg::*;

    sps_peer_state_t s;
    sps_peer_state_t n;
    sps_step_t       st;
    logic            edge_ev;
    logic            half_up;
    logic            din;

    always_comb begin
        n          = s;
        edge_ev    = 1'b0;
        half_up    = (s.div_cnt == 8'(HALF_DIV - 8'h01));
        din        = peer_master_i ? link.miso : link.mosi;
        n.done     = 1'b0;
        n.sck_prev = link.sck;
        n.div_cnt  = half_up ? 8'h00 : 8'(s.div_cnt + 8'h01);
        case (s.phase)
            SPS_IDLE: begin
                n.div_cnt = 8'h00;
                n.ss_n    = 1'b1;
                if (start_i) begin
                    n.shift = tx_byte_i;
                    if (peer_master_i) begin
                        n.ss_n  = 1'b0;
                        n.phase = SPS_SETUP;
                    end
                end
                // only a move away from the idle level opens a frame, not a change of idle level
                if (!peer_master_i && link.sck != s.sck_prev && link.sck != clock_idle_level_i) begin
                    edge_ev = 1'b1;
                    n.phase = SPS_SHIFT;
                end
            end
            SPS_SETUP: begin
                if (half_up) begin
                    n.phase = SPS_SHIFT;
                end
            end
            SPS_SHIFT: begin
                if (peer_master_i) begin
                    if (half_up) begin
                        edge_ev = 1'b1;
                        n.sck   = !s.sck;
                    end
                end else if (link.sck != s.sck_prev) begin
                    edge_ev = 1'b1;
                end
            end
            SPS_HOLD: begin
                if (half_up) begin
                    n.ss_n  = 1'b1;
                    n.phase = SPS_IDLE;
                end
            end
            default: begin
                n.phase = SPS_IDLE;
            end
        endcase
        st = sps_edge_step(s.shift, s.latch, s.edge_cnt, clock_phase_sel_i, din);
        if (edge_ev) begin
            n.shift    = st.shift;
            n.latch    = st.latch;
            n.edge_cnt = 4'(s.edge_cnt + 4'h1);
            if (s.edge_cnt == `SPS_LAST_EDGE) begin
                n.rx    = st.rx;
                n.done  = 1'b1;
                n.phase = peer_master_i ? SPS_HOLD : SPS_IDLE;
            end
        end
        if (n.phase == SPS_IDLE || n.phase == SPS_SETUP) begin
            n.sck = clock_idle_level_i;
        end
        n.busy      = (n.phase != SPS_IDLE);
        // as slave the next bit goes out right after each capture, so a port dividing by 2 still sees it
        n.out_bit   = (n.edge_cnt[0] != clock_phase_sel_i && n.edge_cnt != `SPS_FIRST_EDGE) ? n.shift[6] : n.shift[7];
        n.sck_oe_n  = !peer_master_i;
        n.mosi_oe_n = !peer_master_i;
        n.miso_oe_n = peer_master_i;
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s           <= '0;
            s.ss_n      <= 1'b1;
            s.sck_prev  <= 1'b1;
            s.sck_oe_n  <= 1'b1;
            s.mosi_oe_n <= 1'b1;
            s.miso_oe_n <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign rx_byte_o           = s.rx;
    assign done_o              = s.done;
    assign busy_o              = s.busy;
    assign link.peer_sck_o     = s.sck;
    assign link.peer_sck_oe_n  = s.sck_oe_n;
    assign link.peer_mosi_o    = s.shift[7];
    assign link.peer_mosi_oe_n = s.mosi_oe_n;
    assign link.peer_miso_o    = s.out_bit;
    assign link.peer_miso_oe_n = s.miso_oe_n;
    assign link.ss_n           = s.ss_n;

endmodule : sps_peer

// ===== rtl/sps_dev.sv
// sps_dev.sv: byte-wide serial port, master or slave, with a software register port
// assumes: link pins are synchronous to clock_i; software port strobes are one cycle long
//
// Overview of operation
// - master drives MOSI, samples MISO
// - master's select input must stay high
// - master starts transfer on data write
// - master shifts written byte out MSB first
// - slave shifts written byte out on MISO
// - slave starts on received clock edges
// - slave: MOSI in, MISO out, clock input
// - master holds slave select low per byte; the port drives no select, ss_n is only an input
// - slave ignores rate bits and prescaler
// - done flag set; irq needs source and enable
// - received byte buffered, data reads return it
// - done clears by status then data read
// - data writes ignored while done flag set and status not yet read
// - eight clock pulses shift both ways
// - idle level bit sets resting clock level
// - phase set: launch first, capture second edge
// - phase clear: capture first edge, toggle select
// - selected slave with phase clear freezes its data register
// - write during transfer sets collision flag
// - collision flag never raises an interrupt
// - select low as master: fault, drop roles
// - fault clears by status read, control write
// - rate codes divide by 2, 4, 16, 32
// - irq when one flag sets, other clear
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`include "sps_consts.svh"
module sps_dev (
    input  wire logic               clock_i,
    input  wire logic               nrst_i,
    input  wire sps_pkg::sps_addr_t addr_i,
    input  wire sps_pkg::sps_byte_t wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    output sps_pkg::sps_byte_t      rdata_o,
    output logic                    irq_o,
    sps_if.dev                      link
);
    import sps_pkg::*;

    sps_dev_state_t s;
    sps_dev_state_t n;
    sps_step_t      st;
    logic           master;
    logic           out_en;
    logic           clock_phase_sel;
    logic           selected;
    logic           edge_ev;
    logic           din;
    logic           data_wr;
    logic           data_rd;
    logic           stat_rd;
    logic           ctrl_wr;
    logic           done_rise;
    logic           mode_fault_flag_rise;

    // master half period in system clocks for the rate code
    function automatic logic [4:0] half_period(logic [1:0] rate);
        logic [4:0] h;
        h = `SPS_HALF_R0;
        case (rate)
            2'b00:   h = `SPS_HALF_R0;
            2'b01:   h = `SPS_HALF_R1;
            2'b10:   h = `SPS_HALF_R2;
            2'b11:   h = `SPS_HALF_R3;
            default: h = `SPS_HALF_R0;
        endcase
        return h;
    endfunction : half_period

    always_comb begin
        n          = s;
        master     = s.ctrl[`SPS_CR_MASTER];
        out_en     = s.ctrl[`SPS_CR_OE];
        clock_phase_sel       = s.ctrl[`SPS_CR_CLOCK_PHASE_SEL];
        selected   = !master && out_en && !link.ss_n;
        edge_ev    = 1'b0;
        data_wr    = wr_i && addr_i == `SPS_ADDR_DATA;
        data_rd    = rd_i && addr_i == `SPS_ADDR_DATA;
        stat_rd    = rd_i && addr_i == `SPS_ADDR_STAT;
        ctrl_wr    = wr_i && addr_i == `SPS_ADDR_CTRL;
        din        = master ? link.miso : link.mosi;
        n.rdata    = `SPS_ZERO_BYTE;
        n.irq      = 1'b0;
        n.sck_prev = link.sck;

        // register reads, answered in the next cycle
        if (rd_i) begin
            case (addr_i)
                `SPS_ADDR_DATA: n.rdata = s.rxbuf;
                `SPS_ADDR_CTRL: n.rdata = s.ctrl;
                `SPS_ADDR_STAT: begin
                    n.rdata[`SPS_SR_DONE] = s.done_flag;
                    n.rdata[`SPS_SR_WRITE_COLLISION_FLAG] = s.write_collision_flag_flag;
                    n.rdata[`SPS_SR_MODE_FAULT_FLAG] = s.mode_fault_flag_flag;
                end
                `SPS_ADDR_PRESC: n.rdata = s.presc;
                default: n.rdata = `SPS_ZERO_BYTE;
            endcase
        end

        // first step of each clearing sequence
        if (stat_rd) begin
            n.done_arm = s.done_arm | s.done_flag;
            n.write_collision_flag_arm = s.write_collision_flag_arm | s.write_collision_flag_flag;
            n.mode_fault_flag_arm = s.mode_fault_flag_arm | s.mode_fault_flag_flag;
        end
        if (data_rd && s.done_arm) begin
            n.done_flag = 1'b0;
            n.done_arm  = 1'b0;
        end
        if ((data_rd || data_wr) && s.write_collision_flag_arm) begin
            n.write_collision_flag_flag = 1'b0;
            n.write_collision_flag_arm  = 1'b0;
        end

        // control and prescaler writes
        if (ctrl_wr) begin
            n.ctrl = wdata_i;
            if (s.mode_fault_flag_flag && !s.mode_fault_flag_arm) begin
                n.ctrl[`SPS_CR_OE]     = 1'b0;
                n.ctrl[`SPS_CR_MASTER] = 1'b0;
            end
            if (s.mode_fault_flag_arm) begin
                n.mode_fault_flag_flag = 1'b0;
                n.mode_fault_flag_arm  = 1'b0;
            end
        end
        if (wr_i && addr_i == `SPS_ADDR_PRESC) begin
            n.presc = wdata_i;
        end

        // data write: load the shifter, start as master, or collide
        if (data_wr) begin
            if (s.done_flag && !s.done_arm) begin
                n.shift = s.shift;
            end else if (s.busy || (selected && !clock_phase_sel)) begin
                n.write_collision_flag_flag = 1'b1;
            end else begin
                n.shift = wdata_i;
                if (master && out_en) begin
                    n.busy     = 1'b1;
                    n.edge_cnt = `SPS_FIRST_EDGE;
                    n.div_cnt  = 5'h00;
                end
            end
        end

        // serial clock edges: own divider as master, received clock as slave
        if (master) begin
            if (s.busy) begin
                if (s.div_cnt == 5'(half_period(s.ctrl[`SPS_CR_RATE_HI:`SPS_CR_RATE_LO]) - 5'h01)) begin
                    n.div_cnt = 5'h00;
                    n.sck     = !s.sck;
                    edge_ev   = 1'b1;
                end else begin
                    n.div_cnt = 5'(s.div_cnt + 5'h01);
                end
            end
        end else if (selected && link.sck != s.sck_prev) begin
            edge_ev = 1'b1;
            n.busy  = 1'b1;
        end

        st = sps_edge_step(s.shift, s.latch, s.edge_cnt, clock_phase_sel, din);
        if (edge_ev) begin
            n.shift    = st.shift;
            n.latch    = st.latch;
            n.edge_cnt = 4'(s.edge_cnt + 4'h1);
            if (s.edge_cnt == `SPS_LAST_EDGE) begin
                n.rxbuf     = st.rx;
                n.done_flag = 1'b1;
                n.busy      = 1'b0;
                n.edge_cnt  = `SPS_FIRST_EDGE;
            end
        end

        // a deselected slave drops any partial byte
        if (!master && (link.ss_n || !out_en)) begin
            n.busy     = 1'b0;
            n.edge_cnt = `SPS_FIRST_EDGE;
        end

        // mode fault overrides the enable, role and busy state software set this cycle
        if (master && !link.ss_n) begin
            n.mode_fault_flag_flag            = 1'b1;
            n.ctrl[`SPS_CR_OE]     = 1'b0;
            n.ctrl[`SPS_CR_MASTER] = 1'b0;
            n.busy                 = 1'b0;
            n.edge_cnt             = `SPS_FIRST_EDGE;
        end

        if (!n.busy || !n.ctrl[`SPS_CR_MASTER]) begin
            n.sck = n.ctrl[`SPS_CR_CLOCK_IDLE_LEVEL];
        end

        // one-cycle request; the collision flag plays no part
        done_rise = n.done_flag && !s.done_flag;
        mode_fault_flag_rise = n.mode_fault_flag_flag && !s.mode_fault_flag_flag;
        n.irq     = s.ctrl[`SPS_CR_IRQ_EN] && s.ctrl[`SPS_CR_IRQ_SRC]
                    && ((done_rise && !n.mode_fault_flag_flag) || (mode_fault_flag_rise && !n.done_flag));

        n.sck_oe_n  = !(n.ctrl[`SPS_CR_OE] && n.ctrl[`SPS_CR_MASTER]);
        n.mosi_oe_n = !(n.ctrl[`SPS_CR_OE] && n.ctrl[`SPS_CR_MASTER]);
        n.miso_oe_n = !(n.ctrl[`SPS_CR_OE] && !n.ctrl[`SPS_CR_MASTER] && !link.ss_n);
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s           <= '0;
            s.ctrl      <= `SPS_CTRL_RST;
            s.presc     <= `SPS_PRESC_RST;
            s.sck_oe_n  <= 1'b1;
            s.mosi_oe_n <= 1'b1;
            s.miso_oe_n <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign rdata_o            = s.rdata;
    assign irq_o              = s.irq;
    assign link.dev_sck_o     = s.sck;
    assign link.dev_sck_oe_n  = s.sck_oe_n;
    assign link.dev_mosi_o    = s.shift[7];
    assign link.dev_mosi_oe_n = s.mosi_oe_n;
    assign link.dev_miso_o    = s.shift[7];
    assign link.dev_miso_oe_n = s.miso_oe_n;

endmodule : sps_dev

// ===== dv/sps_monitor.sv
// sps_monitor.sv: link assertions for the port and far end joined by sps_if
// assumes: instantiated in the bench top beside the interface, fed by name
`timescale 1ns/1ps
module sps_monitor (
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic dev_sck_oe_n,
    input wire logic dev_mosi_oe_n,
    input wire logic dev_miso_o,
    input wire logic dev_miso_oe_n,
    input wire logic ss_n,
    input wire logic sck
);
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    logic [4:0] edge_cnt;
    logic       sck_q;
    logic       clean;

    // far-end clock edges within one select frame that the port never drove
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            edge_cnt <= 5'h00;
            sck_q    <= 1'b1;
            clean    <= 1'b1;
        end else begin
            sck_q <= sck;
            if (ss_n) begin
                edge_cnt <= 5'h00;
                clean    <= 1'b1;
            end else begin
                edge_cnt <= edge_cnt + {4'h0, sck ^ sck_q};
                clean    <= clean & dev_sck_oe_n;
            end
        end
    end

    a_pins_pair: assert property (dev_sck_oe_n == dev_mosi_oe_n)
        else $error("clock and data out enables differ");
    a_slave_role: assert property (!dev_miso_oe_n |-> dev_sck_oe_n && dev_mosi_oe_n)
        else $error("slave output drives clock or master data");
    a_unselected_quiet: assert property (ss_n && $past(ss_n) |-> dev_miso_oe_n)
        else $error("unselected slave drives its data out");
    a_launch_between: assert property (!dev_miso_oe_n && $changed(sck) |-> $stable(dev_miso_o))
        else $error("slave data moved on a clock edge");
    a_fault_release: assert property (!dev_sck_oe_n && !ss_n |-> ##[1:3] dev_sck_oe_n [*8])
        else $error("master kept driving with select low");
    a_frame_bounded: assert property ($fell(ss_n) |-> ##[1:100] ss_n)
        else $error("select frame too long");
    a_setup_quiet: assert property ($fell(ss_n) && dev_sck_oe_n |=> $stable(sck) [*3])
        else $error("clock moved right after select");
    a_byte_edges: assert property ($rose(ss_n) && clean |-> edge_cnt == 5'h10)
        else $error("frame without sixteen clock edges");

    c_clean_frame: cover property ($rose(ss_n) && clean);
    c_fault: cover property (!dev_sck_oe_n && !ss_n);
    c_master_drive: cover property ($fell(dev_sck_oe_n));
endmodule : sps_monitor

// ===== dv/sps_tb_top.sv
// sps_tb_top.sv: self-checking bench, port against the far end over sps_if
// assumes: sps_pkg compiled first; one clock at 250 MHz
`timescale 1ns/1ps
`include "sps_consts.svh"
module sps_tb_top;
    import sps_pkg::*;
    localparam logic [7:0] PEER_HALF = `SPS_PEER_HALF;
    logic      clock_i   = 1'b0;
    logic      nrst_i    = 1'b0;
    sps_addr_t addr      = 2'h0;
    sps_byte_t wdata     = 8'h00;
    logic      wr        = 1'b0;
    logic      rd        = 1'b0;
    logic      p_mst     = 1'b0;
    logic      clock_idle_level      = 1'b0;
    logic      clock_phase_sel      = 1'b0;
    logic      p_start   = 1'b0;
    sps_byte_t p_tx      = 8'h00;
    sps_byte_t rdata;
    sps_byte_t p_rx;
    logic      irq;
    logic      p_done;
    logic      p_busy;
    logic      sck_q     = 1'b1;
    int        mismatches = 0;
    int        cmp_count = 0;
    int        cycles    = 0;
    int        edges     = 0;
    int        gap       = 0;
    int        last_gap  = 0;
    int        irqs      = 0;
    // half periods of divide 2, 4, 16, 32
    sps_byte_t halves [4] = '{8'h01, 8'h02, 8'h08, 8'h10};
    sps_byte_t ctl [8]    = '{8'h50, 8'hf5, 8'h5a, 8'hff, 8'h40, 8'he4, 8'h4b, 8'hec};

    sps_if sps_if_inst ();
    sps_dev sps_dev_inst (
        .clock_i (clock_i),
        .nrst_i  (nrst_i),
        .addr_i  (addr),
        .wdata_i (wdata),
        .wr_i    (wr),
        .rd_i    (rd),
        .rdata_o (rdata),
        .irq_o   (irq),
        .link    (sps_if_inst.dev)
    );
    sps_peer #(.HALF_DIV(PEER_HALF)) sps_peer_inst (
        .clock_i       (clock_i),
        .nrst_i        (nrst_i),
        .peer_master_i (p_mst),
        .clock_idle_level_i        (clock_idle_level),
        .clock_phase_sel_i        (clock_phase_sel),
        .tx_byte_i     (p_tx),
        .start_i       (p_start),
        .rx_byte_o     (p_rx),
        .done_o        (p_done),
        .busy_o        (p_busy),
        .link          (sps_if_inst.peer)
    );
    sps_monitor sps_monitor_inst (
        .clock_i       (clock_i),
        .nrst_i        (nrst_i),
        .dev_sck_oe_n  (sps_if_inst.dev_sck_oe_n),
        .dev_mosi_oe_n (sps_if_inst.dev_mosi_oe_n),
        .dev_miso_o    (sps_if_inst.dev_miso_o),
        .dev_miso_oe_n (sps_if_inst.dev_miso_oe_n),
        .ss_n          (sps_if_inst.ss_n),
        .sck           (sps_if_inst.sck)
    );

    always #2 clock_i = ~clock_i;

    // clock edges while someone drives a frame, gap between the last two
    always @(posedge clock_i) begin
        cycles++;
        gap++;
        if (irq === 1'b1) irqs++;
        if (sps_if_inst.sck !== sck_q && !(sps_if_inst.dev_sck_oe_n & sps_if_inst.ss_n)) begin
            edges++;
            last_gap = gap;
            gap = 0;
        end
        sck_q = sps_if_inst.sck;
        if (cycles > 20000) begin
            mismatches++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic chk(string what, sps_byte_t seen, sps_byte_t exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr_reg(sps_addr_t a, sps_byte_t d);
        @(posedge clock_i);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clock_i);
        wr    <= 1'b0;
    endtask : wr_reg

    task automatic rd_chk(sps_addr_t a, sps_byte_t exp, string what);
        @(posedge clock_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clock_i);
        rd   <= 1'b0;
        #1 chk(what, rdata, exp);
    endtask : rd_chk

    task automatic peer_go(logic m, sps_byte_t t);
        @(posedge clock_i);
        p_mst   <= m;
        p_tx    <= t;
        p_start <= 1'b1;
        @(posedge clock_i);
        p_start <= 1'b0;
    endtask : peer_go

    task automatic wait_peer();
        do begin
            @(posedge clock_i);
            #1;
        end while (p_done !== 1'b1);
        repeat (4) @(posedge clock_i);
    endtask : wait_peer

    // one byte each way; bit 4 of c picks the port's role
    task automatic xfer(sps_byte_t c, sps_byte_t d, sps_byte_t p, logic col);
        clock_idle_level <= c[3];
        clock_phase_sel <= c[2];
        p_mst <= !c[4];
        if (c[4]) peer_go(1'b0, p);
        wr_reg(`SPS_ADDR_CTRL, c);
        repeat (2) @(posedge clock_i);
        if (c[4]) #1 chk("idle level", {7'h00, sps_if_inst.sck}, {7'h00, c[3]});
        edges = 0;
        irqs = 0;
        wr_reg(`SPS_ADDR_DATA, d);
        if (!c[4]) peer_go(1'b1, p);
        if (col) begin
            repeat (6) @(posedge clock_i);
            wr_reg(`SPS_ADDR_DATA, ~d);
        end
        wait_peer();
        wr_reg(`SPS_ADDR_DATA, 8'h3c);
        repeat (40) @(posedge clock_i);
        chk("edges", 8'(edges), 8'h10);
        chk("half period", 8'(last_gap), c[4] ? halves[c[1:0]] : PEER_HALF);
        chk("irq count", 8'(irqs), {7'h00, c[7] & c[5]});
        chk("peer rx", p_rx, d);
        rd_chk(`SPS_ADDR_STAT, col ? 8'hc0 : 8'h80, "status");
        rd_chk(`SPS_ADDR_DATA, p, "rx buffer");
        rd_chk(`SPS_ADDR_STAT, 8'h00, "status clear");
    endtask : xfer

    initial begin
        repeat (10) @(posedge clock_i);
        nrst_i <= 1'b1;
        rd_chk(`SPS_ADDR_CTRL, `SPS_CTRL_RST, "ctrl reset");
        rd_chk(`SPS_ADDR_STAT, 8'h00, "status reset");
        rd_chk(`SPS_ADDR_PRESC, `SPS_PRESC_RST, "prescaler reset");
        wr_reg(`SPS_ADDR_PRESC, 8'h5c);
        rd_chk(`SPS_ADDR_PRESC, 8'h5c, "prescaler");
        @(posedge clock_i);
        #1 chk("read idle", rdata, 8'h00);
        for (int i = 0; i < 8; i++) begin
            xfer(ctl[i], 8'ha6 ^ 8'(i), 8'h1d ^ 8'(i << 4), i == 2 || i == 4);
        end
        // far end selects the port while it is master
        wr_reg(`SPS_ADDR_CTRL, 8'hf0);
        clock_idle_level <= 1'b0;
        clock_phase_sel <= 1'b0;
        irqs = 0;
        peer_go(1'b1, 8'h55);
        wait_peer();
        chk("fault irq", 8'(irqs), 8'h01);
        rd_chk(`SPS_ADDR_CTRL, 8'ha0, "ctrl after fault");
        wr_reg(`SPS_ADDR_CTRL, 8'hf0);
        rd_chk(`SPS_ADDR_CTRL, 8'ha0, "ctrl blocked");
        rd_chk(`SPS_ADDR_STAT, 8'h10, "fault status");
        wr_reg(`SPS_ADDR_CTRL, 8'h50);
        rd_chk(`SPS_ADDR_CTRL, 8'h50, "ctrl restored");
        rd_chk(`SPS_ADDR_STAT, 8'h00, "fault clear");
        close_out();
    end
endmodule : sps_tb_top
